// *** bench/data_move_instruction_exec_bench.sv ***
`timescale 1ns/1ps
module data_move_instruction_exec_bench;
  reg         i_clock = 1'b0;
  reg         i_rst_n = 1'b0;
  reg  [15:0] i_instr = 16'h0000;
  reg         i_instr_valid = 1'b0;
  reg         i_ext_en = 1'b0;
  reg  [3:0]  i_bank_sel = 4'h0;
  wire [7:0]  i_rd_data, o_wr_data, o_acc;
  wire [11:0] o_addr, o_ptr0, o_ptr1, o_ptr2;
  wire        o_rd, o_wr, o_busy, o_illegal;
  wire [3:0]  o_phase;
  reg  [7:0]  mem [0:4095];
  reg  [11:0] wa, la;
  reg  [7:0]  ld;
  integer     bad_count = 0, checks = 0, n;
  function [7:0] pat(input [11:0] a);
    pat = a[7:0] ^ {a[11:8], a[11:8]};
  endfunction
  assign i_rd_data = mem[o_addr];
  dmx_exec dmx_exec_inst (.i_clock, .i_rst_n, .i_instr, .i_instr_valid, .i_ext_en, .i_bank_sel, .i_rd_data,
    .o_addr, .o_rd, .o_wr, .o_wr_data, .o_phase, .o_busy, .o_illegal, .o_acc, .o_ptr0, .o_ptr1, .o_ptr2);
  initial forever #25 i_clock = ~i_clock;
  always @(posedge i_clock)
  begin
    if (o_phase[3]) wa <= o_addr;
    if (o_wr)
    begin
      mem[wa] <= o_wr_data;
      la <= wa;
      ld <= o_wr_data;
    end
  end
  task chk(input c);
  begin
    checks = checks + 1;
    if (!c)
    begin
      bad_count = bad_count + 1;
      $display("CHECK FAILED at %0t: mismatch", $time);
    end
  end
  endtask
  task issue(input [15:0] w, input v);
  begin
    @(posedge i_clock) #2;
    while (!o_phase[0]) @(posedge i_clock) #2;
    i_instr = w;
    i_instr_valid = v;
    repeat (3) @(posedge i_clock);
    #2;
  end
  endtask
  task mv(input [15:0] w, input [3:0] bk, input ex, input [11:0] a);
  begin
    i_bank_sel = bk;
    i_ext_en = ex;
    issue(w, 1'b1);
    issue(16'h0000, 1'b0);
    chk(o_acc === pat(a));
  end
  endtask
  task mm(input [11:0] s, input [11:0] d);
  begin
    issue({4'hc, s}, 1'b1);
    issue({4'hf, d}, 1'b1);
    chk(o_busy === 1'b1);
    issue(16'h0000, 1'b0);
    chk(o_busy === 1'b0 && o_illegal === 1'b0);
  end
  endtask
  task t_ptr;
  begin
    for (n = 0; n < 3; n = n + 1)
    begin
      issue({8'hee, 2'b00, n[1:0], n[3:0] + 4'h1}, 1'b1);
      issue(16'hf0ab, 1'b1);
      chk((n == 0 ? o_ptr0 : n == 1 ? o_ptr1 : o_ptr2) === {n[3:0] + 4'h1, 8'h00});
      issue(16'h0000, 1'b0);
      chk((n == 0 ? o_ptr0 : n == 1 ? o_ptr1 : o_ptr2) === {n[3:0] + 4'h1, 8'hab});
    end
  end
  endtask
  task t_mv;
  begin
    mv(16'h5121, 4'h5, 1'b0, 12'h521);
    mv(16'h5090, 4'h5, 1'b0, 12'hf90);
    mv(16'h5040, 4'h5, 1'b0, 12'h040);
    mv(16'h505f, 4'h5, 1'b1, 12'h40a);
    mv(16'h5060, 4'h5, 1'b1, 12'h060);
    mv(16'h51ff, 4'hf, 1'b0, 12'hfff);
    mv(16'h5322, 4'h6, 1'b0, 12'hfff);
    chk(la === 12'h622 && ld === pat(12'h622));
  end
  endtask
  task t_mm;
  begin
    mm(12'h123, 12'habc);
    chk(la === 12'habc && ld === pat(12'h123));
    mm(12'hfff, 12'h000);
    chk(la === 12'h000 && mem[12'h000] === pat(12'hfff));
    mm(12'h456, 12'hfe8);
    chk(o_acc === pat(12'h456));
    mm(12'hfe8, 12'h200);
    chk(la === 12'h200 && ld === pat(12'h456));
    issue(16'hc100, 1'b1);
    issue(16'he200, 1'b1);
    issue(16'h0000, 1'b0);
    chk(o_illegal === 1'b1);
  end
  endtask
  task conclude;
  begin
    $display("checks %0d bad_count %0d", checks, bad_count);
    if (bad_count == 0 && checks > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  end
  endtask
  initial
  begin
    for (n = 0; n < 4096; n = n + 1) mem[n] = pat(n[11:0]);
    repeat (6) @(posedge i_clock);
    #2 i_rst_n = 1'b1;
    t_ptr;
    t_mv;
    t_mm;
    conclude;
  end
  initial
  begin
    #100000;
    bad_count = bad_count + 1;
    conclude;
  end
endmodule // data_move_instruction_exec_bench

// *** bench/dmx_exec_assertions.sv ***
`timescale 1ns/1ps
module dmx_exec_assertions (
  input wire        i_clock,
  input wire        i_rst_n,
  input wire [15:0] i_instr,
  input wire        i_instr_valid,
  input wire        i_ext_en,
  input wire [3:0]  i_bank_sel,
  input wire [11:0] o_addr,
  input wire        o_rd,
  input wire        o_wr,
  input wire [3:0]  o_phase,
  input wire [7:0]  o_acc,
  input wire [11:0] o_ptr2
);
  default clocking @(posedge i_clock); endclocking
  default disable iff (!i_rst_n);
  wire q2  = o_phase[1] && i_instr_valid;
  wire mvf = q2 && i_instr[15:10] == 6'h14;
  sequence mm_first;
    q2 && i_instr[15:12] == 4'hc;
  endsequence
  sequence mm_dest;
    i_instr_valid && i_instr[15:12] == 4'hf && i_instr[11:0] != 12'hfe8;
  endsequence
  phase_one_hot_a: assert property ($onehot(o_phase)) else $error("phase not one-hot");
  phase_step_a: assert property (o_phase[1] |=> o_phase[2] ##1 o_phase[3] ##1 o_phase[0])
    else $error("phase order broken");
  read_in_q2_a: assert property (o_rd |-> o_phase[1]) else $error("read outside q2");
  write_pulse_a: assert property (o_wr |-> $past(o_phase[3]) ##1 !o_wr) else $error("bad write pulse");
  acc_hold_a: assert property (!o_phase[3] |=> $stable(o_acc)) else $error("acc moved early");
  ptr_hold_a: assert property (!o_phase[3] |=> $stable(o_ptr2)) else $error("pointer moved early");
  bank_addr_a: assert property (mvf && i_instr[8] |-> o_rd && o_addr == {i_bank_sel, i_instr[7:0]})
    else $error("banked address wrong");
  access_addr_a: assert property (mvf && !i_instr[8] && !i_ext_en |-> o_addr == {{4{i_instr[7]}}, i_instr[7:0]})
    else $error("access address wrong");
  index_addr_a: assert property (mvf && !i_instr[8] && i_ext_en && i_instr[7:0] <= 8'h5f
    |-> o_addr == o_ptr2 + {4'h0, i_instr[7:0]}) else $error("indexed address wrong");
  move_src_a: assert property (mm_first |-> o_rd == (i_instr[11:0] != 12'hfe8) && o_addr == i_instr[11:0])
    else $error("source read wrong");
  move_dest_a: assert property (mm_first ##3 mm_dest ##3 o_phase[3] |-> o_addr == i_instr[11:0] ##1 o_wr)
    else $error("dest write wrong");
endmodule // dmx_exec_assertions
bind dmx_exec dmx_exec_assertions dmx_exec_assertions_inst (.i_clock, .i_rst_n, .i_instr, .i_instr_valid,
  .i_ext_en, .i_bank_sel, .o_addr, .o_rd, .o_wr, .o_phase, .o_acc, .o_ptr2);

// *** hdl/dmx_addr_resolve.v ***
`timescale 1ns/1ps
`include "dmx_defines.vh"
module dmx_addr_resolve (
  input  wire [7:0]  i_faddr,
  input  wire        i_bank_bit,
  input  wire [3:0]  i_bank_sel,
  input  wire        i_ext_en,
  input  wire [11:0] i_ptr2,
  output reg  [11:0] o_addr
);
  always @*
  begin
    if (i_bank_bit)
      o_addr = {i_bank_sel, i_faddr};
    else if (i_ext_en && (i_faddr <= `DMX_IDX_LIMIT))
      o_addr = i_ptr2 + {4'h0, i_faddr};
    else if (i_faddr < `DMX_ACCESS_SPLIT)
      o_addr = {4'h0, i_faddr};
    else
      o_addr = {`DMX_SFR_PAGE, i_faddr};
  end
endmodule // dmx_addr_resolve

// *** hdl/dmx_defines.vh ***
// Summary of operation
// - pointer load writes its 12-bit literal into the selected one of three pointers.
// - register move 0101_00da copies addressed register to destination chosen by d.
// - d zero sends result to accumulator; d one writes it back to register.
// - the 8-bit register address reaches any byte of the selected 256-byte bank.
// - bank bit zero, outside the indexed case below, resolves the address inside the fixed access bank.
// - bank bit one uses bank select register as upper address bits.
// - extended set, bank bit zero, address at most 95 uses indexed literal offset.
// - memory move takes 12-bit source and destination across 000h to FFFh.
// - memory move words are 1100 plus source, then 1111 plus destination.
// - memory move may name the accumulator as source or destination like memory.
// - memory move occupies two words and two instruction cycles.
`ifndef DMX_DEFINES_VH
`define DMX_DEFINES_VH
`define DMX_OP_PTR_LOAD   8'hee
`define DMX_OP_PTR_LOAD2  8'hf0
`define DMX_OP_REG_MOVE   6'h14
`define DMX_OP_MEM_MOVE   4'hc
`define DMX_OP_SECOND     4'hf
`define DMX_IDX_LIMIT     8'h5f
`define DMX_ACC_ADDR      12'hfe8
`define DMX_PTR0_LOW      12'hfe9
`define DMX_PTR1_LOW      12'hfe1
`define DMX_PTR2_LOW      12'hfd9
`define DMX_ACCESS_SPLIT  8'h80
`define DMX_SFR_PAGE      4'hf
`endif

// *** hdl/dmx_exec.v ***
`timescale 1ns/1ps
`include "dmx_defines.vh"
module dmx_exec (
  input  wire        i_clock,
  input  wire        i_rst_n,
  input  wire [15:0] i_instr,
  input  wire        i_instr_valid,
  input  wire        i_ext_en,
  input  wire [3:0]  i_bank_sel,
  input  wire [7:0]  i_rd_data,
  output reg  [11:0] o_addr,
  output reg         o_rd,
  output reg         o_wr,
  output reg  [7:0]  o_wr_data,
  output wire [3:0]  o_phase,
  output wire        o_busy,
  output wire        o_illegal,
  output wire [7:0]  o_acc,
  output wire [11:0] o_ptr0,
  output wire [11:0] o_ptr1,
  output wire [11:0] o_ptr2
);
  localparam ST_IDLE = 3'b001;
  localparam ST_PTR2 = 3'b010;
  localparam ST_MOV2 = 3'b100;
  reg  [2:0]  state_r;
  reg  [2:0]  state_nxt;
  reg  [15:0] ir_r;
  reg  [1:0]  psel_r;
  reg  [3:0]  phigh_r;
  reg  [11:0] ptr_r [0:2];
  reg  [7:0]  acc_r;
  reg  [7:0]  data_r;
  reg         illegal_r;
  reg  [11:0] res_addr_r;
  wire [3:0]  ph;
  wire [11:0] res_addr;
  wire        is_ptr;
  wire        is_rmov;
  wire        is_mmov;
  dmx_phase_gen u_phase (
    .i_clock (i_clock),
    .i_rst_n (i_rst_n),
    .o_phase (ph)
  );
  dmx_addr_resolve u_res (
    .i_faddr    (i_instr[7:0]),
    .i_bank_bit (i_instr[8]),
    .i_bank_sel (i_bank_sel),
    .i_ext_en   (i_ext_en),
    .i_ptr2     (ptr_r[2]),
    .o_addr     (res_addr)
  );
  assign o_phase = ph;
  assign is_ptr  = (i_instr[15:8] == `DMX_OP_PTR_LOAD) && (i_instr[5:4] != 2'b11);
  assign is_rmov = (i_instr[15:10] == `DMX_OP_REG_MOVE);
  assign is_mmov = (i_instr[15:12] == `DMX_OP_MEM_MOVE);
  assign o_busy  = (state_r != ST_IDLE);
  assign o_illegal = illegal_r;
  assign o_acc   = acc_r;
  assign o_ptr0  = ptr_r[0];
  assign o_ptr1  = ptr_r[1];
  assign o_ptr2  = ptr_r[2];
  function [7:0] rd_byte;
    input [11:0] a;
    begin
      if (a == `DMX_ACC_ADDR)
        rd_byte = acc_r;
      else
        rd_byte = i_rd_data;
    end
  endfunction
  always @*
  begin
    state_nxt = state_r;
    case (state_r)
      ST_IDLE:
      begin
        if (ph[3] && i_instr_valid && is_ptr)
          state_nxt = ST_PTR2;
        else if (ph[3] && i_instr_valid && is_mmov)
          state_nxt = ST_MOV2;
      end
      ST_PTR2: if (ph[3] && i_instr_valid) state_nxt = ST_IDLE;
      ST_MOV2: if (ph[3] && i_instr_valid) state_nxt = ST_IDLE;
      default: state_nxt = ST_IDLE;
    endcase
  end
  always @*
  begin
    o_addr = 12'h000;
    o_rd   = 1'b0;
    if (state_r == ST_IDLE && i_instr_valid && ph[1])
    begin
      if (is_rmov)
      begin
        o_addr = res_addr;
        o_rd   = 1'b1;
      end
      else if (is_mmov)
      begin
        o_addr = i_instr[11:0];
        o_rd   = (i_instr[11:0] != `DMX_ACC_ADDR);
      end
    end
    else if (state_r == ST_IDLE && ph[3])
      o_addr = res_addr_r;
    else if (state_r == ST_MOV2 && ph[3])
      o_addr = i_instr[11:0];
  end
  always @(posedge i_clock)
  begin
    if (!i_rst_n)
    begin
      state_r    <= ST_IDLE;
      ir_r       <= 16'h0000;
      psel_r     <= 2'h0;
      phigh_r    <= 4'h0;
      ptr_r[0]   <= 12'h000;
      ptr_r[1]   <= 12'h000;
      ptr_r[2]   <= 12'h000;
      acc_r      <= 8'h00;
      data_r     <= 8'h00;
      illegal_r  <= 1'b0;
      res_addr_r <= 12'h000;
      o_wr       <= 1'b0;
      o_wr_data  <= 8'h00;
    end
    else
    begin
      state_r <= state_nxt;
      o_wr    <= 1'b0;
      if (ph[0] && i_instr_valid)
        ir_r <= i_instr;
      if (state_r == ST_IDLE && i_instr_valid && ph[1])
      begin
        if (is_rmov)
        begin
          data_r     <= rd_byte(res_addr);
          res_addr_r <= res_addr;
        end
        else if (is_mmov)
          data_r <= rd_byte(i_instr[11:0]);
      end
      if (state_r == ST_IDLE && i_instr_valid && ph[2] && is_ptr)
      begin
        psel_r  <= i_instr[5:4];
        phigh_r <= i_instr[3:0];
      end
      if (state_r == ST_IDLE && i_instr_valid && ph[3])
      begin
        if (is_ptr)
          ptr_r[i_instr[5:4]] <= {i_instr[3:0], ptr_r[i_instr[5:4]][7:0]};
        else if (is_rmov && !i_instr[9])
          acc_r <= data_r;
        else if (is_rmov)
        begin
          o_wr      <= 1'b1;
          o_wr_data <= data_r;
        end
      end
      if (state_r == ST_PTR2 && ph[3] && i_instr_valid)
      begin
        illegal_r <= (i_instr[15:8] != `DMX_OP_PTR_LOAD2);
        ptr_r[psel_r] <= {phigh_r, i_instr[7:0]};
      end
      if (state_r == ST_MOV2 && ph[3] && i_instr_valid)
      begin
        illegal_r <= (i_instr[15:12] != `DMX_OP_SECOND);
        if (i_instr[11:0] == `DMX_ACC_ADDR)
          acc_r <= data_r;
        else
        begin
          o_wr      <= 1'b1;
          o_wr_data <= data_r;
        end
      end
    end
  end
endmodule // dmx_exec

// *** hdl/dmx_phase_gen.v ***
`timescale 1ns/1ps
module dmx_phase_gen (
  input  wire       i_clock,
  input  wire       i_rst_n,
  output wire [3:0] o_phase
);
  reg [3:0] phase_r;
  always @(posedge i_clock)
  begin
    if (!i_rst_n)
      phase_r <= 4'h1;
    else
      phase_r <= {phase_r[2:0], phase_r[3]};
  end
  assign o_phase = phase_r;
endmodule // dmx_phase_gen
